// ==== src/event_chained_transfer_engine.sv ====
// interrupt-activated chained transfer engine with axi4-lite registers and interval timer
`timescale 1ns/1ps
`default_nettype none
module event_chained_transfer_engine
  import ecte_pkg::*;
#(
  parameter int unsigned N_IRQ   = 64,
  parameter int unsigned DESC_N  = 16,
  parameter logic [31:0] TMR_CMP = TMR_CMP_RST,
  parameter int unsigned TDIV    = TICK_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic [N_IRQ-1:0] irq_i,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // transfer bus master
  output logic             mem_valid_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic             mem_half_o,
  output logic [15:0]      mem_wdata_o,
  input  wire logic        mem_ready_i,
  input  wire logic [15:0] mem_rdata_i,
  // system status
  output logic             snooze_req_o,
  output logic             chain_end_o
);
  localparam int unsigned IDX_W = $clog2(DESC_N);
  initial begin
    if (N_IRQ <= TIMER_IRQ_BIT || N_IRQ > 64) $error("N_IRQ must be 34..64");
    if (DESC_N < 2 || (1 << IDX_W) != DESC_N || DESC_N * 16 > 4096 - 64)
      $error("DESC_N must be a power of two that fits the map");
  end

  function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  function automatic logic in_desc(input logic [11:0] a);
    return (a >= OFS_DESC_BASE) && (a < 12'(OFS_DESC_BASE + 16 * DESC_N));
  endfunction

  function automatic logic [IDX_W-1:0] desc_idx(input logic [11:0] a);
    logic [11:0] r;
    r = a - OFS_DESC_BASE;
    return r[IDX_W+3:4];
  endfunction

  function automatic logic [15:0] units_of(input logic [31:0] cfg);
    return (xfer_mode_e'(cfg[CFG_MODE_LSB +: 2]) == MODE_BLOCK) ? cfg[CFG_LEN_LSB +: 16] : 16'h0001;
  endfunction

  // descriptor table and control registers
  logic [31:0]      cfg_q [DESC_N];
  logic [31:0]      src_q [DESC_N];
  logic [31:0]      dst_q [DESC_N];
  logic [15:0]      cnt_q [DESC_N];
  logic [63:0]      en_q;
  logic [IDX_W-1:0] start_q;
  logic             tmr_en_q;
  logic [31:0]      tmr_cmp_q;
  logic [N_IRQ-1:0] pend_q;
  eng_state_e       st_q;
  logic [IDX_W-1:0] idx_q;
  logic [15:0]      blk_q;
  logic [15:0]      units_q;
  logic             bvalid_q, rvalid_q, end_q;
  logic [1:0]       bresp_q, rresp_q;
  logic [31:0]      rdata_q;

  // engine view of the current descriptor
  logic [31:0]      c_cfg;
  xfer_mode_e       c_mode;
  logic [15:0]      c_len;
  logic [31:0]      step;
  logic             c_chain, c_last;
  logic             take;
  logic [5:0]       take_idx;
  logic [N_IRQ-1:0] req;
  logic             buf_in_ready, buf_out_valid, wr_done, is_tmr, tmr_clr;
  logic [15:0]      buf_out_data;
  logic [31:0]      tmr_cnt;
  logic             tmr_flag, tmr_match;
  logic             aw_go, ar_go;
  logic [IDX_W-1:0] wi;

  assign c_cfg   = cfg_q[idx_q];
  assign c_mode  = xfer_mode_e'(c_cfg[CFG_MODE_LSB +: 2]);
  assign c_len   = c_cfg[CFG_LEN_LSB +: 16];
  assign step    = c_cfg[CFG_SIZE_BIT] ? 32'h0000_0002 : 32'h0000_0001;
  assign c_chain = c_cfg[CFG_CHAIN];
  assign c_last  = (idx_q == IDX_W'(DESC_N - 1));

  long_interval_timer #(.DIV(TDIV)) u_timer (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .enable_i   (tmr_en_q),
    .cmp_i      (tmr_cmp_q),
    .flag_clr_i (tmr_clr),
    .count_o    (tmr_cnt),
    .flag_o     (tmr_flag),
    .match_o    (tmr_match)
  );

  // gate sources by their enable bit; the timer joins at its fixed bit
  always_comb begin
    req = irq_i & en_q[N_IRQ-1:0];
    req[TIMER_IRQ_BIT] = (irq_i[TIMER_IRQ_BIT] | tmr_match) & en_q[TIMER_IRQ_BIT];
    take_idx = 6'h00;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (pend_q[i] && en_q[i]) take_idx = 6'(i);
    end
  end
  // a pending source whose enable was cleared waits instead of starting
  assign take = ce_i && (st_q == ENG_IDLE) && ((pend_q & en_q[N_IRQ-1:0]) != '0);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) pend_q <= '0;
    else if (ce_i) pend_q <= (pend_q & ~(take ? (N_IRQ'(1) << take_idx) : '0)) | req;
  end

  // data path: read side fills the buffer, write side drains it
  assign is_tmr       = (dst_q[idx_q] == TMR_STATUS_ADDR);
  assign wr_done      = ce_i && (st_q == ENG_WRITE) && buf_out_valid && (is_tmr || mem_ready_i);
  assign tmr_clr      = wr_done && is_tmr && !buf_out_data[TMR_FLAG_BIT];
  assign mem_valid_o  = ce_i && ((st_q == ENG_READ) ? buf_in_ready
                      : (st_q == ENG_WRITE) && buf_out_valid && !is_tmr);
  assign mem_we_o     = (st_q == ENG_WRITE);
  assign mem_addr_o   = (st_q == ENG_WRITE) ? dst_q[idx_q] : src_q[idx_q];
  assign mem_half_o   = c_cfg[CFG_SIZE_BIT];
  assign mem_wdata_o  = buf_out_data;
  assign snooze_req_o = (st_q != ENG_IDLE);
  assign chain_end_o  = end_q;

  xfer_skid_buf #(.W(16)) u_buf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  ((st_q == ENG_READ) && mem_ready_i),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_rdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (wr_done),
    .out_data_o  (buf_out_data)
  );

  // activation sequencer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q    <= ENG_IDLE;
      idx_q   <= '0;
      blk_q   <= 16'h0000;
      units_q <= 16'h0000;
      end_q   <= 1'b0;
    end else if (ce_i) begin
      end_q <= 1'b0;
      case (st_q)
        ENG_IDLE: begin
          if (take) begin
            st_q    <= ENG_READ;
            idx_q   <= start_q;
            blk_q   <= units_of(cfg_q[start_q]);
            units_q <= 16'h0000;
          end
        end
        ENG_READ: begin
          if (mem_ready_i && buf_in_ready) st_q <= ENG_WRITE;
        end
        ENG_WRITE: begin
          if (wr_done) begin
            units_q <= units_q + 16'h0001;
            blk_q   <= blk_q - 16'h0001;
            st_q    <= (blk_q <= 16'h0001) ? ENG_NEXT : ENG_READ;
          end
        end
        ENG_NEXT: begin
          if (c_chain && !c_last) begin
            st_q    <= ENG_READ;
            idx_q   <= idx_q + IDX_W'(1);
            blk_q   <= units_of(cfg_q[idx_q + IDX_W'(1)]);
            units_q <= 16'h0000;
          end else begin
            st_q  <= ENG_IDLE;
            end_q <= 1'b1;
          end
        end
        default: st_q <= ENG_IDLE;
      endcase
    end
  end

  // axi4-lite handshake: write address and data are taken together
  assign aw_go         = ce_i && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign ar_go         = ce_i && s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = aw_go;
  assign s_axi_wready  = aw_go;
  assign s_axi_arready = ar_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wi            = desc_idx(s_axi_awaddr);

  // descriptor table: the engine write-back wins over software on the same entry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DESC_N; i++) begin
        cfg_q[i] <= CFG_RST | {RESULT_BUF_LEN, 16'h0000};
        src_q[i] <= 32'h0000_0000;
        dst_q[i] <= 32'h0000_0000;
        cnt_q[i] <= RESULT_BUF_LEN;
      end
    end else if (ce_i) begin
      if (aw_go && in_desc(s_axi_awaddr)) begin
        case (s_axi_awaddr[3:2])
          DW_CFG:  cfg_q[wi] <= strb_merge(cfg_q[wi], s_axi_wdata, s_axi_wstrb);
          DW_SRC:  src_q[wi] <= strb_merge(src_q[wi], s_axi_wdata, s_axi_wstrb);
          DW_DST:  dst_q[wi] <= strb_merge(dst_q[wi], s_axi_wdata, s_axi_wstrb);
          default: cnt_q[wi] <= 16'(strb_merge({16'h0000, cnt_q[wi]}, s_axi_wdata, s_axi_wstrb));
        endcase
      end
      if (wr_done) begin
        if (c_cfg[CFG_SRC_INC]) src_q[idx_q] <= src_q[idx_q] + step;
        if (c_cfg[CFG_DST_INC]) dst_q[idx_q] <= dst_q[idx_q] + step;
      end
      if (st_q == ENG_NEXT) begin
        if (c_mode == MODE_REPEAT && cnt_q[idx_q] <= 16'h0001) begin
          cnt_q[idx_q] <= c_len;
          if (c_cfg[CFG_RPT_DST] && c_cfg[CFG_DST_INC])
            dst_q[idx_q] <= dst_q[idx_q] - step * 32'(c_len);
          else if (!c_cfg[CFG_RPT_DST] && c_cfg[CFG_SRC_INC])
            src_q[idx_q] <= src_q[idx_q] - step * 32'(c_len);
        end else if (cnt_q[idx_q] != 16'h0000) begin
          cnt_q[idx_q] <= cnt_q[idx_q] - 16'h0001;
        end
      end
    end
  end

  // control registers and bus answers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q      <= 64'h0000_0000_0000_0000;
      start_q   <= '0;
      tmr_en_q  <= 1'b0;
      tmr_cmp_q <= TMR_CMP;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce_i) begin
      if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
      if (aw_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= RESP_OKAY;
        case (s_axi_awaddr)
          OFS_EN_SET0: en_q[31:0] <= en_q[31:0] | (s_axi_wdata & {{8{s_axi_wstrb[3]}},
                         {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}});
          OFS_EN_SET1: en_q[63:32] <= strb_merge(en_q[63:32], s_axi_wdata, s_axi_wstrb);
          OFS_START:   if (s_axi_wstrb[0]) start_q <= s_axi_wdata[IDX_W-1:0];
          OFS_TMR_CTRL: if (s_axi_wstrb[0]) tmr_en_q <= s_axi_wdata[0];
          OFS_TMR_CMP: tmr_cmp_q <= strb_merge(tmr_cmp_q, s_axi_wdata, s_axi_wstrb);
          default:     if (!in_desc(s_axi_awaddr)) bresp_q <= RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ce_i) begin
      if (rvalid_q && s_axi_rready) rvalid_q <= 1'b0;
      if (ar_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        rdata_q  <= 32'h0000_0000;
        if (in_desc(s_axi_araddr)) begin
          case (s_axi_araddr[3:2])
            DW_CFG:  rdata_q <= cfg_q[desc_idx(s_axi_araddr)];
            DW_SRC:  rdata_q <= src_q[desc_idx(s_axi_araddr)];
            DW_DST:  rdata_q <= dst_q[desc_idx(s_axi_araddr)];
            default: rdata_q <= {16'h0000, cnt_q[desc_idx(s_axi_araddr)]};
          endcase
        end else begin
          case (s_axi_araddr)
            OFS_EN_SET0:  rdata_q <= en_q[31:0];
            OFS_EN_SET1:  rdata_q <= en_q[63:32];
            OFS_START:    rdata_q <= 32'(start_q);
            OFS_STATUS:   rdata_q <= {16'h0000, 4'h0, 4'(idx_q), 6'h00, tmr_flag, snooze_req_o};
            OFS_TMR_CTRL: rdata_q <= {31'h0000_0000, tmr_en_q};
            OFS_TMR_CMP:  rdata_q <= tmr_cmp_q;
            OFS_TMR_CNT:  rdata_q <= tmr_cnt;
            default:      rresp_q <= RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // checks
  sequence s_act_start;
    (st_q == ENG_IDLE) && take ##1 (st_q == ENG_READ);
  endsequence

  property p_take_enabled;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_act_start |-> $past(en_q[take_idx]);
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("start without enable");

  property p_single_unit;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == ENG_NEXT) && (c_mode != MODE_BLOCK) |-> units_q == 16'h0001;
  endproperty
  a_single_unit: assert property (p_single_unit) else $error("non-block moved more than one");

  property p_block_len;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == ENG_NEXT) && (c_mode == MODE_BLOCK) && (c_len != 16'h0000) |-> units_q == c_len;
  endproperty
  a_block_len: assert property (p_block_len) else $error("block length mismatch");

  property p_repeat_reload;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && (st_q == ENG_NEXT) && (c_mode == MODE_REPEAT) && (cnt_q[idx_q] == 16'h0001)
      |=> cnt_q[$past(idx_q)] == $past(c_len);
  endproperty
  a_repeat_reload: assert property (p_repeat_reload) else $error("repeat count not reloaded");

  property p_chain_next;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && (st_q == ENG_NEXT) && c_chain && !c_last
      |=> (st_q == ENG_READ) && (idx_q == $past(idx_q) + IDX_W'(1));
  endproperty
  a_chain_next: assert property (p_chain_next) else $error("chain did not advance");

  property p_chain_stop;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && (st_q == ENG_NEXT) && !c_chain |=> (st_q == ENG_IDLE) && chain_end_o;
  endproperty
  a_chain_stop: assert property (p_chain_stop) else $error("chain did not stop");

  property p_snooze_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(snooze_req_o) |-> $past(st_q) == ENG_NEXT && chain_end_o;
  endproperty
  a_snooze_hold: assert property (p_snooze_hold) else $error("snooze request dropped early");

  property p_dst_step;
    @(posedge clk_i) disable iff (!rst_b_i)
      wr_done && c_cfg[CFG_DST_INC] && c_cfg[CFG_SIZE_BIT]
      |=> dst_q[$past(idx_q)] == $past(dst_q[idx_q]) + 32'h0000_0002;
  endproperty
  a_dst_step: assert property (p_dst_step) else $error("destination did not advance by 2");

  property p_flag_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      tmr_clr && !tmr_match |=> !tmr_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("timer flag not cleared");
endmodule
`default_nettype wire

// ==== src/ecte_pkg.sv ====
// shared constants for the event chained transfer engine
package ecte_pkg;
  // timing
  localparam int unsigned    SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned    TICK_US        = 1;
  localparam int unsigned    TICK_DIV       = SYS_CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned    ACQ_PERIOD_MIN = 30;
  localparam longint         ACQ_TICKS      = longint'(ACQ_PERIOD_MIN) * 60 * 1_000_000 / TICK_US;
  localparam logic [31:0]    TMR_CMP_RST    = 32'(ACQ_TICKS - 1);
  localparam logic [15:0]    RESULT_BUF_LEN = 16'h0060;
  // register offsets
  localparam logic [11:0]    OFS_EN_SET0    = 12'h000;
  localparam logic [11:0]    OFS_EN_SET1    = 12'h004;
  localparam logic [11:0]    OFS_START      = 12'h008;
  localparam logic [11:0]    OFS_STATUS     = 12'h00C;
  localparam logic [11:0]    OFS_TMR_CTRL   = 12'h010;
  localparam logic [11:0]    OFS_TMR_CMP    = 12'h014;
  localparam logic [11:0]    OFS_TMR_CNT    = 12'h018;
  localparam logic [11:0]    OFS_DESC_BASE  = 12'h040;
  // descriptor word select: 0 cfg, 1 src, 2 dst, 3 count
  localparam logic [1:0]     DW_CFG         = 2'h0;
  localparam logic [1:0]     DW_SRC         = 2'h1;
  localparam logic [1:0]     DW_DST         = 2'h2;
  localparam logic [1:0]     DW_CNT         = 2'h3;
  // cfg word fields (transfer mode register b)
  localparam int unsigned    CFG_MODE_LSB   = 0;
  localparam int unsigned    CFG_SIZE_BIT   = 2;
  localparam int unsigned    CFG_SRC_INC    = 3;
  localparam int unsigned    CFG_DST_INC    = 4;
  localparam int unsigned    CFG_CHAIN      = 5;
  localparam int unsigned    CFG_RPT_DST    = 6;
  localparam int unsigned    CFG_LEN_LSB    = 16;
  localparam logic [31:0]    CFG_RST        = 32'h0000_0000;
  // interrupt source wired to the long interval timer
  localparam int unsigned    TIMER_IRQ_BIT  = 33;
  localparam int unsigned    TMR_FLAG_BIT   = 0;
  localparam logic [31:0]    TMR_STATUS_ADDR = 32'h4000_0100;
  // status fields
  localparam int unsigned    ST_BUSY_BIT    = 0;
  localparam int unsigned    ST_TFLAG_BIT   = 1;
  localparam int unsigned    ST_IDX_LSB     = 8;
  localparam logic [1:0]     RESP_OKAY      = 2'b00;
  localparam logic [1:0]     RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_BLOCK  = 2'b10
  } xfer_mode_e;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_READ  = 2'b01,
    ENG_WRITE = 2'b10,
    ENG_NEXT  = 2'b11
  } eng_state_e;
endpackage

// ==== src/xfer_skid_buf.sv ====
// two-entry valid/ready buffer in the transfer data path
`timescale 1ns/1ps
`default_nettype none
module xfer_skid_buf #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  initial begin
    if (W == 0) $error("width must be nonzero");
  end

  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o & ce_i;
  assign pop         = out_valid_o & out_ready_i & ce_i;

  always_ff @(posedge clk_i) begin
    if (push) mem_q[wp_q] <= in_data_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ==== src/long_interval_timer.sv ====
// four cascaded 8-bit channels forming one 32-bit interval counter
`timescale 1ns/1ps
`default_nettype none
module long_interval_timer
  import ecte_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        enable_i,
  input  wire logic [31:0] cmp_i,
  input  wire logic        flag_clr_i,
  output logic [31:0]      count_o,
  output logic             flag_o,
  output logic             match_o
);
  initial begin
    if (DIV < 1 || DIV > 65535) $error("tick divider out of range");
  end

  logic [15:0] pre_q;
  logic        tick;
  logic [3:0]  carry;
  logic [31:0] cnt_q;
  logic        flag_q;

  assign tick    = enable_i && (pre_q == 16'(DIV - 1));
  assign match_o = ce_i && tick && (cnt_q == cmp_i);
  assign count_o = cnt_q;
  assign flag_o  = flag_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) pre_q <= 16'h0000;
    else if (ce_i) pre_q <= (!enable_i || tick) ? 16'h0000 : pre_q + 16'h0001;
  end

  // channel 0 advances on the tick; each higher channel advances only on the carry of the one below it
  always_comb begin
    carry[0] = tick;
    for (int c = 1; c < 4; c++) begin
      carry[c] = carry[c-1] && (cnt_q[8*c-8 +: 8] == 8'hFF);
    end
  end

  // one process owns the whole counter so no slice has a second driver
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 32'h0000_0000;
    end else if (match_o) begin
      cnt_q <= 32'h0000_0000;
    end else if (ce_i) begin
      for (int c = 0; c < 4; c++) begin
        if (carry[c]) cnt_q[8*c +: 8] <= cnt_q[8*c +: 8] + 8'h01;
      end
    end
  end

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) flag_q <= 1'b0;
    else if (match_o) flag_q <= 1'b1;
    else if (ce_i && flag_clr_i) flag_q <= 1'b0;
  end

  property p_match_wraps;
    @(posedge clk_i) disable iff (!rst_b_i)
      match_o |=> (cnt_q == 32'h0000_0000) && flag_q;
  endproperty
  a_match_wraps: assert property (p_match_wraps) else $error("match did not wrap and flag");
endmodule
`default_nettype wire

// ==== sim/xfer_mem_model.sv ====
// transfer bus slave: small halfword memory with optional stall
`timescale 1ns/1ps
`default_nettype none
module xfer_mem_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        v_i,
  input  wire logic        we_i,
  input  wire logic [31:0] a_i,
  input  wire logic [15:0] wd_i,
  input  wire logic        hw_i,
  output logic             rdy_o,
  output logic [15:0]      rd_o
);
  logic [15:0] m [64];
  logic        t_q = 1'b0;
  int          wr_n = 0;
  logic        hw_q = 1'b0;
  // the converter side raises no snooze request of its own here
  assign rdy_o = v_i && (!slow_i || t_q);
  // data outside an answer is inverted so a stale word never passes
  assign rd_o = (rdy_o && !we_i) ? m[a_i[6:1]] : ~m[a_i[6:1]];
  always @(posedge clk_i) begin
    t_q <= !t_q;
    if (rdy_o && we_i) begin
      wr_n <= wr_n + 1;
      hw_q <= hw_i;
      m[a_i[6:1]] <= wd_i;
    end
  end
endmodule
`default_nettype wire

// ==== sim/event_chained_transfer_engine_bench.sv ====
// bench for the chained transfer engine
`timescale 1ns/1ps
`default_nettype none
module event_chained_transfer_engine_bench;
  import ecte_pkg::*;
  logic clk_i = 0, rst_b_i = 0, slow = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [63:0] irq = '0;
  logic [11:0] aa = '0;
  logic [31:0] wd = '0, rd, ma, d;
  logic awr, wrr, bv, arr, rv, mv, mwe, mrdy, snz, ce_o, mh;
  logic [1:0] bresp, rresp, r;
  logic [15:0] mwd, mrd;
  int failures = 0, checks = 0, n;
  always #25 clk_i = ~clk_i;
  event_chained_transfer_engine dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .irq_i(irq), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aa),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(aa), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .mem_valid_o(mv), .mem_we_o(mwe),
    .mem_addr_o(ma), .mem_half_o(mh), .mem_wdata_o(mwd), .mem_ready_i(mrdy),
    .mem_rdata_i(mrd), .snooze_req_o(snz), .chain_end_o(ce_o));
  xfer_mem_model u_mem (.clk_i(clk_i), .slow_i(slow), .v_i(mv), .we_i(mwe), .a_i(ma),
    .wd_i(mwd), .hw_i(mh), .rdy_o(mrdy), .rd_o(mrd));
  task finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task lim(input int b);
    if (n >= b) begin
      failures++;
      finish_test;
    end
  endtask
  // aw and w offered together; each bus task starts a fresh edge
  task wr32(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    awv <= 1; wv <= 1; aa <= a; wd <= v; br <= 1;
    n = 0;
    do @(negedge clk_i); while (!(awr && wrr) && ++n < 99);
    @(posedge clk_i);
    awv <= 0; wv <= 0;
    do @(negedge clk_i); while (!bv && ++n < 99);
    r = bresp;
    @(posedge clk_i);
    br <= 0;
    lim(99);
  endtask
  task rd32(input logic [11:0] a);
    @(posedge clk_i);
    arv <= 1; aa <= a; rr <= 1;
    n = 0;
    do @(negedge clk_i); while (!arr && ++n < 99);
    @(posedge clk_i);
    arv <= 0;
    do @(negedge clk_i); while (!rv && ++n < 99);
    d = rd; r = rresp;
    @(posedge clk_i);
    rr <= 0;
    lim(99);
  endtask
  task wait_end(input int b);
    n = 0;
    do @(negedge clk_i); while (!ce_o && ++n < b);
    lim(b);
  endtask
  task kick;
    @(posedge clk_i);
    irq[TIMER_IRQ_BIT] <= 1;
    @(posedge clk_i);
    irq[TIMER_IRQ_BIT] <= 0;
  endtask
  task t_regs;
    rd32(OFS_DESC_BASE);
    chk("cfg reset", d, 32'h0060_0000);
    rd32(12'h020);
    chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    wr32(12'h020, 32'h0);
    chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
    $display("test regs done");
  endtask
  task t_gate;
    kick;
    repeat (40) @(posedge clk_i);
    chk("gated writes", u_mem.wr_n, 0);
    $display("test gate done");
  endtask
  task t_chain;
    logic [31:0] tb [8];
    // step 2 has fixed addresses and ends the chain like the last dummy transfer
    tb = '{32'h0002_0075, 32'h10, 32'h60, 32'h2, 32'h0001_0000, 32'h20, 32'h30, 32'h3};
    for (int i = 0; i < 8; i++) wr32(OFS_DESC_BASE + 12'(4 * i), tb[i]);
    wr32(OFS_EN_SET1, 32'h0000_0002);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) u_mem.m[48] = '0;
      slow <= (k == 1);
      kick;
      wait_end(300);
      chk("snooze at end", 32'(snz), 0);
      chk("byte unit", 32'(u_mem.hw_q), 0);
      chk("write count", u_mem.wr_n, 2 * (k + 1));
      chk("ring slot", 32'(u_mem.m[48 + k % 2]), 32'hA5C3);
      chk("second step", 32'(u_mem.m[24][7:0]), 32'h5A);
    end
    $display("test chain done");
  endtask
  task t_block;
    wr32(OFS_DESC_BASE + 12'h020, 32'h0002_001E);
    wr32(OFS_DESC_BASE + 12'h024, 32'h10);
    wr32(OFS_DESC_BASE + 12'h028, 32'h40);
    wr32(OFS_START, 32'h2);
    kick;
    wait_end(300);
    chk("block writes", u_mem.wr_n, 8);
    chk("block word 0", 32'(u_mem.m[32]), 32'hA5C3);
    chk("block word 1", 32'(u_mem.m[33]), 32'h3C5A);
    chk("halfword unit", 32'(u_mem.hw_q), 1);
    $display("test block done");
  endtask
  // a compare above 8 bits only matches if channel 0 carries into channel 1
  task t_timer;
    wr32(OFS_START, 32'h0);
    wr32(OFS_DESC_BASE + 12'h018, TMR_STATUS_ADDR);
    wr32(OFS_TMR_CMP, 32'h0000_0100);
    wr32(OFS_TMR_CTRL, 32'h1);
    wait_end(8000);
    chk("timer period", 32'(n >= 256 * TICK_DIV), 1);
    chk("timer activation", u_mem.wr_n, 9);
    rd32(OFS_STATUS);
    chk("timer flag", 32'(d[ST_TFLAG_BIT]), 0);
    wr32(OFS_TMR_CTRL, 32'h0);
    $display("test timer done");
  endtask
  initial begin
    u_mem.m[8] = 16'hA5C3;
    u_mem.m[16] = 16'h005A;
    u_mem.m[9] = 16'h3C5A;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    t_regs;
    t_gate;
    t_chain;
    t_block;
    t_timer;
    finish_test;
  end
endmodule
`default_nettype wire
